// ---- hw/iodc_top.sv ----
// interrupt request pin stage with holdoff interval and config register
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module iodc_top
   import iodc_pkg::*;
(
   // clock and reset
   input  wire  logic              clk,
   input  wire  logic              rst,
   input  wire  logic              soft_rst,
   // interrupt sources, same clock domain
   input  wire  logic [SRC_W-1:0]  src_active,
   input  wire  logic [SRC_W-1:0]  src_enable,
   // register port
   input  wire  logic [ADDR_W-1:0] addr,
   input  wire  logic [DATA_W-1:0] wdata,
   input  wire  logic              wr_stb,
   input  wire  logic              rd_stb,
   output logic       [DATA_W-1:0] rdata,
   // interrupt request pin
   output logic                    irq_pin_out,
   output logic                    irq_pin_oe_n,
   // block event interrupt
   output logic                    evt_irq
);

   // address decode shared by read and write paths
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   iodc_cfg_t         cfg_q;        // configuration register state
   logic              master;       // internal master interrupt line
   logic              wr_cfg;       // write to configuration
   logic              wr_sts;       // write to event status
   logic              wr_mask;      // write to event mask
   logic [7:0]        ivl_new;      // interval written this cycle
   logic              clr_req;      // counter clear request
   logic              run_q;        // holdoff interval running
   logic [TICK_W-1:0] tick_q;       // cycles within one unit
   logic [7:0]        units_q;      // units left in interval
   logic              unit_end;     // last cycle of a unit
   logic              expire;       // last cycle of the interval
   logic              asrt;         // interrupt offered to the pin
   logic              asrt_q;       // previous offer, for release edge
   logic              release_ev;   // offer to the pin went inactive
   logic              start;        // begin a fresh interval
   logic              stop_zero;    // interval disabled by zero
   iodc_pin_t         pin_q;        // registered pin drive
   logic [EVT_W-1:0]  sts_q;        // sticky event bits
   logic [EVT_W-1:0]  mask_q;       // event mask
   logic [EVT_W-1:0]  evt_set;      // events this cycle
   logic [DATA_W-1:0] rdata_q;      // read data register

   // master line: any enabled source active
   assign master = |(src_active & src_enable);

   // write decode
   assign wr_cfg  = wr_stb && hit(addr, OFS_CFG);
   assign wr_sts  = wr_stb && hit(addr, OFS_EVT_STS);
   assign wr_mask = wr_stb && hit(addr, OFS_EVT_MASK);
   assign ivl_new = wdata[POS_IVL_HI:POS_IVL_LO];
   // clear bit is a pulse only, nothing is stored so it reads back zero
   assign clr_req = wr_cfg && wdata[POS_CLR];

   // configuration register; reserved bits have no storage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_q.interval     <= IVL_RST;
         cfg_q.out_en       <= EN_RST;
         cfg_q.pin_polarity <= POL_RST;
         cfg_q.buf_type     <= TYPE_RST;
      end else if (soft_rst) begin
         // polarity and type are kept across soft reset
         cfg_q.interval     <= IVL_RST;
         cfg_q.out_en       <= EN_RST;
      end else if (wr_cfg) begin
         cfg_q.interval     <= ivl_new;
         cfg_q.out_en       <= wdata[POS_EN];
         cfg_q.pin_polarity <= wdata[POS_POL];
         cfg_q.buf_type     <= wdata[POS_TYPE];
      end
   end

   // holdoff control terms
   // a zero field, current or being written, disables the interval at once
   // a write decides on its own value, so a non-zero write with clear restarts
   assign stop_zero = wr_cfg ? (ivl_new == IVL_RST) : (cfg_q.interval == IVL_RST);
   assign unit_end  = run_q && (tick_q == TICK_LAST);
   assign expire    = unit_end && (units_q == 8'h01);
   // interrupts are withheld from the pin while the interval runs
   assign asrt       = master && !run_q;
   assign release_ev = asrt_q && !asrt;
   assign start      = !stop_zero && (release_ev || clr_req);

   // release edge tracking
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         asrt_q <= 1'b0;
      end else if (soft_rst) begin
         asrt_q <= 1'b0;
      end else begin
         asrt_q <= asrt;
      end
   end

   // holdoff run flag
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_q <= 1'b0;
      end else if (soft_rst || stop_zero) begin
         run_q <= 1'b0;
      end else if (start) begin
         run_q <= 1'b1;
      end else if (expire) begin
         run_q <= 1'b0;
      end
   end

   // tick and unit counters; the interval latches its length at start,
   // so a non-zero rewrite without clear during a running interval only shapes the next one
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_q  <= '0;
         units_q <= IVL_RST;
      end else if (soft_rst || stop_zero) begin
         tick_q  <= '0;
         units_q <= IVL_RST;
      end else if (start) begin
         tick_q  <= '0;
         units_q <= wr_cfg ? ivl_new : cfg_q.interval;
      end else if (unit_end) begin
         tick_q  <= '0;
         units_q <= units_q - 8'h01;
      end else if (run_q) begin
         tick_q  <= tick_q + TICK_W'(1);
      end
   end

   // pin drive; enable gates only this stage, status stays untouched
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_q.out  <= 1'b0;
         pin_q.oe_n <= 1'b1;
      end else if (cfg_q.buf_type == TYPE_OPEN_DRAIN) begin
         // low when asserted, released otherwise
         pin_q.out  <= 1'b0;
         pin_q.oe_n <= !(asrt && cfg_q.out_en);
      end else begin
         // push-pull always drives, inactive level is the inverse
         pin_q.out  <= (asrt && cfg_q.out_en) ? cfg_q.pin_polarity
                                              : !cfg_q.pin_polarity;
         pin_q.oe_n <= 1'b0;
      end
   end
   assign irq_pin_out  = pin_q.out;
   assign irq_pin_oe_n = pin_q.oe_n;

   // block events: interval ended, interrupt offered to the pin
   assign evt_set[EVT_EXPIRE] = expire;
   assign evt_set[EVT_ASSERT] = asrt && !asrt_q;

   // sticky status; a set in the clearing cycle wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sts_q <= EVT_RST;
      end else if (soft_rst) begin
         sts_q <= evt_set;
      end else if (wr_sts) begin
         sts_q <= (sts_q & ~wdata[EVT_W-1:0]) | evt_set;
      end else begin
         sts_q <= sts_q | evt_set;
      end
   end

   // event mask
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_q <= EVT_RST;
      end else if (soft_rst) begin
         mask_q <= EVT_RST;
      end else if (wr_mask) begin
         mask_q <= wdata[EVT_W-1:0];
      end
   end
   assign evt_irq = |(sts_q & mask_q);

   // read data, valid the cycle after the strobe only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (!rd_stb) begin
         rdata_q <= '0;
      end else if (hit(addr, OFS_CFG)) begin
         rdata_q                        <= '0;
         rdata_q[POS_IVL_HI:POS_IVL_LO] <= cfg_q.interval;
         rdata_q[POS_ACTIVE]            <= run_q;
         rdata_q[POS_MASTER]            <= master;
         rdata_q[POS_EN]                <= cfg_q.out_en;
         rdata_q[POS_POL]               <= cfg_q.pin_polarity;
         rdata_q[POS_TYPE]              <= cfg_q.buf_type;
      end else if (hit(addr, OFS_EVT_STS)) begin
         rdata_q <= {{(DATA_W-EVT_W){1'b0}}, sts_q};
      end else if (hit(addr, OFS_EVT_MASK)) begin
         rdata_q <= {{(DATA_W-EVT_W){1'b0}}, mask_q};
      end else begin
         // unmapped addresses read zero
         rdata_q <= '0;
      end
   end
   assign rdata = rdata_q;

   // checks, all in the clk domain
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic              irq_active_pin; // pin shows an interrupt
   logic [TICK_W-1:0] unit_age_q;     // cycles since the current unit began
   assign irq_active_pin = (cfg_q.buf_type == TYPE_OPEN_DRAIN) ? !pin_q.oe_n
                         : (pin_q.out == cfg_q.pin_polarity);

   // unit age for the length check; a counter, since a long delay would crawl
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unit_age_q <= '0;
      end else if (!run_q || start || unit_end || soft_rst || stop_zero) begin
         unit_age_q <= '0;
      end else begin
         unit_age_q <= unit_age_q + TICK_W'(1);
      end
   end

   // a release with a non-zero interval and no soft reset
   sequence s_release;
      asrt_q && !asrt && (cfg_q.interval != IVL_RST) && !wr_cfg && !soft_rst;
   endsequence
   // the interval then runs on
   sequence s_running;
      run_q && !irq_active_pin;
   endsequence

   // release starts the interval and keeps the pin quiet
   AST_RELEASE_HOLDS: assert property (s_release |=> s_running)
      else $error("release did not start holdoff");
   // one unit lasts exactly one tick count
   AST_UNIT_LEN: assert property (
      run_q |-> (unit_end == (unit_age_q == TICK_LAST)) && (unit_age_q <= TICK_LAST))
      else $error("unit length wrong");
   // zero interval write stops interval next cycle
   AST_ZERO_STOPS: assert property (
      (wr_cfg && ivl_new == IVL_RST) |=> !run_q && (asrt == master))
      else $error("zero interval did not release");
   // clear restarts counting from a full length
   AST_CLR_RESTART: assert property (
      (clr_req && ivl_new != IVL_RST && !soft_rst)
      |=> run_q && tick_q == '0 && units_q == $past(ivl_new))
      else $error("clear did not restart interval");
   // clear bit reads back zero
   AST_CLR_READS_ZERO: assert property (
      $past(rd_stb) && $past(addr) == OFS_CFG |-> !rdata[POS_CLR])
      else $error("clear bit read as one");
   // status and master bits mirror state
   AST_STATUS_BITS: assert property (
      (rd_stb && hit(addr, OFS_CFG))
      |=> rdata[POS_ACTIVE] == $past(run_q) && rdata[POS_MASTER] == $past(master))
      else $error("status bits wrong");
   // reserved bits of the configuration word always read zero
   AST_RESERVED_ZERO: assert property (
      $past(rd_stb) && $past(addr) == OFS_CFG |-> (rdata & 32'h00ff8eee) == '0)
      else $error("reserved bits nonzero");
   // with no config write, a disabled output never shows an interrupt
   AST_EN_OFF_QUIET: assert property (
      !cfg_q.out_en && !wr_cfg && !soft_rst |=> !irq_active_pin)
      else $error("pin active while disabled");
   // open drain never drives high
   AST_OD_LOW: assert property (
      (cfg_q.buf_type == TYPE_OPEN_DRAIN) ##1 1'b1 |-> !pin_q.oe_n |-> !pin_q.out)
      else $error("open drain drove high");
   // push-pull always drives
   AST_PP_DRIVES: assert property (
      $past(cfg_q.buf_type) == TYPE_PUSH_PULL |-> !pin_q.oe_n)
      else $error("push-pull released pin");
   // soft reset keeps polarity and type
   AST_SOFT_KEEP: assert property (
      soft_rst |=> $stable(cfg_q.pin_polarity) && $stable(cfg_q.buf_type))
      else $error("soft reset lost kept bits");
   // pin stays quiet one cycle after any holdoff cycle with no config write
   AST_HOLD_GATES: assert property (run_q && !wr_cfg |=> !irq_active_pin)
      else $error("interrupt offered during holdoff");

endmodule
`default_nettype wire

// ---- hw/iodc_pkg.sv ----
// constants, types and register map of the interrupt output stage
package iodc_pkg;
   // bus widths
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned SRC_W  = 32;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CFG       = 12'h054;
   localparam logic [ADDR_W-1:0] OFS_EVT_STS   = 12'h3f0;
   localparam logic [ADDR_W-1:0] OFS_EVT_MASK  = 12'h3f4;
   // configuration field positions
   localparam int unsigned POS_IVL_LO = 24;
   localparam int unsigned POS_IVL_HI = 31;
   localparam int unsigned POS_CLR    = 14;
   localparam int unsigned POS_ACTIVE = 13;
   localparam int unsigned POS_MASTER = 12;
   localparam int unsigned POS_EN     = 8;
   localparam int unsigned POS_POL    = 4;
   localparam int unsigned POS_TYPE   = 0;
   // event bit positions in status and mask
   localparam int unsigned EVT_W       = 2;
   localparam int unsigned EVT_EXPIRE  = 0;
   localparam int unsigned EVT_ASSERT  = 1;
   // reset values
   localparam logic [7:0]       IVL_RST  = 8'h00;
   localparam logic             EN_RST   = 1'b0;
   localparam logic             POL_RST  = 1'b0;
   localparam logic             TYPE_RST = 1'b0;
   localparam logic [EVT_W-1:0] EVT_RST  = 2'h0;
   // timing: one interval unit in ns at a 10 ns clock
   localparam int unsigned UNIT_NS  = 10000;
   localparam int unsigned CLK_NS   = 10;
   localparam int unsigned TICK_W   = 10;
   localparam logic [TICK_W-1:0] TICKS_PER_UNIT = TICK_W'((UNIT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TICK_W-1:0] TICK_LAST      = TICK_W'(TICKS_PER_UNIT - TICK_W'(1));
   // buffer type encoding
   localparam logic TYPE_OPEN_DRAIN = 1'b0;
   localparam logic TYPE_PUSH_PULL  = 1'b1;
   // software-writable configuration
   typedef struct packed {
      logic [7:0] interval;  // holdoff units
      logic       out_en;    // final pin enable
      logic       pin_polarity;
      logic       buf_type;  // open-drain or push-pull
   } iodc_cfg_t;
   // pin drive: level and active-low enable
   typedef struct packed {
      logic out;
      logic oe_n;
   } iodc_pin_t;
endpackage

// ---- tb/iodc_host_model.sv ----
// host side of the interrupt pin: wire resolution and request sensing
`timescale 1ns/1ps
`default_nettype none
module iodc_host_model (
   // pin as driven by the device
   input  wire logic pin_out,
   input  wire logic pin_oe_n,
   // how the host expects the pin to be configured
   input  wire logic push_pull,
   input  wire logic act_high,
   // sensed wire level and request
   output logic      level,
   output logic      irq_seen
);
   // board pull-up: a released pin floats high, never holds the last value
   assign level = pin_oe_n ? 1'b1 : pin_out;
   // open-drain sharing is always sensed low; push-pull per polarity
   assign irq_seen = push_pull ? (level == act_high) : !level;
endmodule
`default_nettype wire

// ---- tb/tb_iodc_top.sv ----
// self-checking bench for the interrupt output stage
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s exp %h got %h", n, e, g); end end
module tb_iodc_top;
   import iodc_pkg::*;
   // design stimulus and response
   logic              clk, rst, soft_rst, wr_stb, rd_stb;
   logic [SRC_W-1:0]  src_active, src_enable;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d;
   logic              irq_pin_out, irq_pin_oe_n, evt_irq;
   // host view
   logic              pp, ah, level, host_irq;
   int                error_cnt, samples_checked, cyc;

   iodc_top uut (.clk(clk), .rst(rst), .soft_rst(soft_rst), .src_active(src_active),
      .src_enable(src_enable), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .irq_pin_out(irq_pin_out),
      .irq_pin_oe_n(irq_pin_oe_n), .evt_irq(evt_irq));
   iodc_host_model host (.pin_out(irq_pin_out), .pin_oe_n(irq_pin_oe_n), .push_pull(pp),
      .act_high(ah), .level(level), .irq_seen(host_irq));

   // clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // verdict, reached from the main sequence or the hang guard
   task automatic results;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      addr   <= a;
      wdata  <= v;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   // one-cycle read strobe, data taken in the following cycle only
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 v = rdata;
   endtask

   // wait n cycles then settle past the edge
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // hang guard; whole run needs well under 15000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end

   // main sequence
   initial begin
      rst = 1'b1; soft_rst = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0;
      addr = '0; wdata = '0; src_active = '0; src_enable = '0;
      pp = 1'b0; ah = 1'b0; cyc = 0; error_cnt = 0; samples_checked = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // reset state and an unmapped place
      rd(OFS_CFG, d); `CHK("cfg reset", 32'h0, d)
      `CHK("pin reset", 2'h2, {irq_pin_oe_n, irq_pin_out})
      rd(12'h100, d); `CHK("unmapped", 32'h0, d)
      // reserved and read-only bits ignore writes, clear bit self-clears
      wr(OFS_CFG, 32'h00ff_ffff); rd(OFS_CFG, d);
      `CHK("cfg rsvd", 32'h0000_0111, d)
      // active but not enabled source leaves master low
      src_active <= 32'h8; wt(2); rd(OFS_CFG, d);
      `CHK("master off", 1'b0, d[POS_MASTER])
      src_enable <= 32'h8; pp = 1'b1; ah = 1'b1; wt(3); rd(OFS_CFG, d);
      `CHK("master on", 1'b1, d[POS_MASTER])
      `CHK("pp high", 2'h1, {irq_pin_oe_n, irq_pin_out})
      wr(OFS_CFG, 32'h0000_0101); ah = 1'b0; wt(2);
      `CHK("pp low", 2'h0, {irq_pin_oe_n, irq_pin_out})
      `CHK("host pp", 1'b1, host_irq)
      // open drain asserts low even with polarity high
      wr(OFS_CFG, 32'h0000_0110); pp = 1'b0; wt(2);
      `CHK("od act", 2'h0, {irq_pin_oe_n, irq_pin_out})
      // output disabled: pin quiet, master still visible
      wr(OFS_CFG, 32'h0000_0010); wt(2);
      `CHK("host off", 1'b0, host_irq)
      rd(OFS_CFG, d); `CHK("master gated", 1'b1, d[POS_MASTER])
      // holdoff of one unit after the pin releases
      wr(OFS_CFG, 32'h0100_0110); wt(2);
      `CHK("od on", 1'b1, host_irq)
      src_active <= '0; wt(3); rd(OFS_CFG, d);
      `CHK("holdoff sts", 1'b1, d[POS_ACTIVE])
      src_active <= 32'h8; wt(500);
      `CHK("held", 1'b0, host_irq)
      wt(600); `CHK("released", 1'b1, host_irq)
      // expiry event through status, mask and write-one clear
      rd(OFS_EVT_STS, d); `CHK("evt expire", 1'b1, d[EVT_EXPIRE])
      `CHK("evt assert", 1'b1, d[EVT_ASSERT])
      `CHK("evt masked", 1'b0, evt_irq)
      wr(OFS_EVT_MASK, 32'h1); wt(1); `CHK("evt irq", 1'b1, evt_irq)
      wr(OFS_EVT_STS, 32'h1); wt(1); `CHK("evt clr", 1'b0, evt_irq)
      // zero interval releases a held request at once
      src_active <= '0; wt(3); src_active <= 32'h8; wt(100);
      `CHK("held2", 1'b0, host_irq)
      wr(OFS_CFG, 32'h0000_0110); wt(2);
      `CHK("zero ivl", 1'b1, host_irq)
      rd(OFS_CFG, d); `CHK("zero sts", 1'b0, d[POS_ACTIVE])
      // new interval of two units governs the next holdoff
      wr(OFS_CFG, 32'h0200_0110);
      src_active <= '0; wt(3); src_active <= 32'h8; wt(1500);
      `CHK("two units", 1'b0, host_irq)
      wt(600); `CHK("two done", 1'b1, host_irq)
      // clear in mid-interval restarts the count
      src_active <= '0; wt(3); src_active <= 32'h8; wt(1000);
      wr(OFS_CFG, 32'h0200_4110); wt(1500);
      `CHK("restart", 1'b0, host_irq)
      rd(OFS_CFG, d); `CHK("clr reads 0", 1'b0, d[POS_CLR])
      wt(600); `CHK("restart end", 1'b1, host_irq)
      // soft reset keeps polarity and buffer type only
      wr(OFS_CFG, 32'h0300_0111);
      @(posedge clk);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
      rd(OFS_CFG, d); `CHK("soft rst", 32'h0000_1011, d)
      rd(OFS_EVT_MASK, d); `CHK("soft mask", 32'h0, d)
      results();
   end
endmodule
`default_nettype wire
